//--- hw/tsh_device.sv
// device end: host port, register set, memories and error/DMA status
`timescale 1ns/10ps
`default_nettype none
module tsh_device (
  input wire logic clk,
  input wire logic rst,
  tsh_port_if.device pins,
  input wire logic style,
  input wire logic bus_clock_4m,
  input wire logic pll_locked,
  input wire logic [tsh_pkg::DMA_CH-1:0] dma_event,
  input wire logic core_dm_we,
  input wire logic [tsh_pkg::MEM_AW-1:0] core_dm_addr,
  input wire logic [tsh_pkg::SAMPLE_W-1:0] core_dm_wdata,
  input wire logic [tsh_pkg::MEM_AW-1:0] core_cm_addr,
  output logic [tsh_pkg::CM_W-1:0] core_cm_q
);
  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_DONE} tsh_dev_state_t;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers: first stage feeds only the second
  // bit 0 upwards: ad, a, ale, cs_n, rd_ds_n, wr_rw_n, xfer_grant, bus_clock_4m
  // idle pin levels, so no false ale edge or grant shows right after reset
  localparam logic [16:0] SYNC_IDLE = 17'h038FF;
  logic [16:0] s1_reg;
  logic [16:0] s2_reg;
  logic ale_d_reg;
  logic clk4_d_reg;
  logic [7:0] ad_s;
  logic [1:0] a_s;
  logic ale_s;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  logic [1:0] gnt_s;
  logic clk4_s;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= SYNC_IDLE;
      s2_reg <= SYNC_IDLE;
      ale_d_reg <= 1'b0;
      clk4_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= {bus_clock_4m, pins.xfer_grant, pins.wr_rw_n, pins.rd_ds_n, pins.cs_n,
        pins.ale, pins.a, pins.ad};
      s2_reg <= s1_reg;
      ale_d_reg <= ale_s;
      clk4_d_reg <= clk4_s;
    end
  end
  assign ad_s = s2_reg[7:0];
  assign a_s = s2_reg[9:8];
  assign ale_s = s2_reg[10];
  assign cs_s = ~s2_reg[11] | (|gnt_s);
  assign rd_s = ~s2_reg[12];
  assign wr_s = s2_reg[13];
  assign gnt_s = s2_reg[15:14];
  assign clk4_s = s2_reg[16];

  ////////////////////////////////////////////////////////////////////////
  // access decode
  logic ds_style;
  logic strobe_on;
  logic is_read;
  logic is_write;
  logic mux_reg;
  logic mux_next;
  logic [7:0] alat_reg;
  logic [7:0] alat_next;
  logic [1:0] reg_idx;
  assign ds_style = (style == tsh_pkg::TSH_STYLE_DS);
  // data-strobe style: one strobe plus direction; strobe style: separate strobes
  assign strobe_on = ds_style ? rd_s : (rd_s | ~wr_s);
  assign is_read = ds_style ? wr_s : rd_s;
  assign is_write = ds_style ? ~wr_s : ~wr_s;
  assign reg_idx = mux_reg ? alat_reg[1:0] : a_s;

  always_comb
  begin
    mux_next = mux_reg;
    alat_next = alat_reg;
    if (ale_s)
    begin
      mux_next = 1'b1;
    end
    if (ale_d_reg && !ale_s)
    begin
      alat_next = ad_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and memories
  logic [7:0] addr_lo_reg;
  logic [7:0] addr_lo_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] cm_tmp_reg;
  logic [7:0] cm_tmp_next;
  logic [tsh_pkg::SAMPLE_W-1:0] dm_mem [tsh_pkg::CHANNELS];
  logic [tsh_pkg::CM_W-1:0] cm_mem [tsh_pkg::CHANNELS];
  logic [tsh_pkg::MEM_AW-1:0] maddr;
  logic dm_we;
  logic cm_we;
  logic [7:0] rdata;
  tsh_dev_state_t state_reg;
  tsh_dev_state_t state_next;
  logic go;
  assign maddr = {ctrl_reg[tsh_pkg::CTRL_ADDR8], addr_lo_reg};
  // switching core owns the write port; host waits while core_dm_we is high rather than collide
  assign go = (state_reg == ST_ACCESS) && !core_dm_we;

  always_comb
  begin
    addr_lo_next = addr_lo_reg;
    ctrl_next = ctrl_reg;
    cm_tmp_next = cm_tmp_reg;
    dm_we = 1'b0;
    cm_we = 1'b0;
    rdata = 8'h00;
    if (reg_idx == tsh_pkg::REG_ADDR_LO)
    begin
      rdata = addr_lo_reg;
    end
    else if (reg_idx == tsh_pkg::REG_CTRL)
    begin
      rdata = ctrl_reg;
      rdata[tsh_pkg::CTRL_ERR] = pins.err;
    end
    else if (reg_idx == tsh_pkg::REG_DATA)
    begin
      rdata = ctrl_reg[tsh_pkg::CTRL_SEL_CM] ? cm_mem[maddr][7:0] : dm_mem[maddr];
    end
    else
    begin
      rdata = {4'h0, cm_mem[maddr][tsh_pkg::CM_W-1:tsh_pkg::SAMPLE_W]};
    end
    if (go && is_write)
    begin
      if (reg_idx == tsh_pkg::REG_ADDR_LO)
      begin
        addr_lo_next = ad_s;
      end
      else if (reg_idx == tsh_pkg::REG_CTRL)
      begin
        ctrl_next = ad_s & tsh_pkg::CTRL_WMASK;
      end
      else if (reg_idx == tsh_pkg::REG_DATA)
      begin
        if (ctrl_reg[tsh_pkg::CTRL_SEL_CM])
        begin
          cm_tmp_next = ad_s;
        end
        else
        begin
          dm_we = 1'b1;
        end
      end
      else
      begin
        cm_we = 1'b1;
      end
    end
  end

  // memories carry no reset so their contents survive a chip reset
  always_ff @(posedge clk)
  begin
    if (core_dm_we)
    begin
      dm_mem[core_dm_addr] <= core_dm_wdata;
    end
    else if (dm_we)
    begin
      dm_mem[maddr] <= ad_s;
    end
    if (cm_we)
    begin
      cm_mem[maddr] <= {ad_s[tsh_pkg::CM_HI_W-1:0], cm_tmp_reg};
    end
    core_cm_q <= cm_mem[core_cm_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  // handshake state machine
  logic [7:0] ad_o_reg;
  logic [7:0] ad_o_next;
  logic ad_oe_reg;
  logic ad_oe_next;
  logic rdy_reg;
  logic rdy_next;
  logic ack_reg;
  logic ack_next;
  always_comb
  begin
    state_next = state_reg;
    ad_o_next = ad_o_reg;
    ad_oe_next = 1'b0;
    rdy_next = 1'b0;
    ack_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (cs_s && strobe_on)
        begin
          state_next = ST_ACCESS;
          rdy_next = !ds_style;
        end
      end
      ST_ACCESS:
      begin
        rdy_next = !ds_style;
        if (go)
        begin
          ad_o_next = rdata;
          // data drives on the edge that ready is released, so the host never sees idle bus
          ad_oe_next = cs_s && strobe_on && is_read;
          rdy_next = 1'b0;
          state_next = ST_DONE;
        end
      end
      default:
      begin
        ad_oe_next = cs_s && strobe_on && is_read;
        ack_next = ds_style && cs_s && strobe_on;
        if (!(cs_s && strobe_on))
        begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // error and DMA requests
  logic [tsh_pkg::LOSS_W-1:0] loss_cnt_reg;
  logic [tsh_pkg::LOSS_W-1:0] loss_cnt_next;
  logic ovr_reg;
  logic ovr_next;
  logic err_reg;
  logic err_next;
  logic [1:0] req_reg;
  logic [1:0] req_next;
  logic clk_lost;
  assign clk_lost = (loss_cnt_reg == tsh_pkg::LOSS_W'(tsh_pkg::BUS_CLK_LOSS_CYC));
  always_comb
  begin
    loss_cnt_next = loss_cnt_reg;
    // any edge of the bus clock restarts the loss count
    if (clk4_s != clk4_d_reg)
    begin
      loss_cnt_next = '0;
    end
    else if (!clk_lost)
    begin
      loss_cnt_next = loss_cnt_reg + 1'b1;
    end
    req_next = req_reg;
    ovr_next = ovr_reg;
    for (int i = 0; i < tsh_pkg::DMA_CH; i++)
    begin
      if (state_reg == ST_DONE && gnt_s[i])
      begin
        req_next[i] = 1'b0;
      end
      if (dma_event[i] && ctrl_reg[tsh_pkg::CTRL_DMA_EN])
      begin
        req_next[i] = 1'b1;
        ovr_next = ovr_next | req_reg[i];
      end
    end
    err_next = clk_lost | ovr_reg | ~pll_locked;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      mux_reg <= 1'b0;
      alat_reg <= 8'h00;
      addr_lo_reg <= 8'h00;
      ctrl_reg <= 8'h00;
      cm_tmp_reg <= 8'h00;
      ad_o_reg <= 8'h00;
      ad_oe_reg <= 1'b0;
      rdy_reg <= 1'b0;
      ack_reg <= 1'b0;
      loss_cnt_reg <= '0;
      ovr_reg <= 1'b0;
      err_reg <= 1'b0;
      req_reg <= 2'h0;
    end
    else
    begin
      state_reg <= state_next;
      mux_reg <= mux_next;
      alat_reg <= alat_next;
      addr_lo_reg <= addr_lo_next;
      ctrl_reg <= ctrl_next;
      cm_tmp_reg <= cm_tmp_next;
      ad_o_reg <= ad_o_next;
      ad_oe_reg <= ad_oe_next;
      rdy_reg <= rdy_next;
      ack_reg <= ack_next;
      loss_cnt_reg <= loss_cnt_next;
      ovr_reg <= ovr_next;
      err_reg <= err_next;
      req_reg <= req_next;
    end
  end

  assign pins.ad_dev_o = ad_o_reg;
  assign pins.ad_dev_oe = ad_oe_reg;
  assign pins.rdy_low = rdy_reg;
  assign pins.ack_low = ack_reg;
  assign pins.err = err_reg;
  assign pins.xfer_request = req_reg;
endmodule // tsh_device
`default_nettype wire

//--- hw/tsh_pkg.sv
// constants and types shared by both ends of the time-slot switch host port
package tsh_pkg;
  localparam int CLK_NS = 25;
  // four periods of the 4 MHz bus clock with no edge means it is gone
  localparam int BUS_CLK_LOSS_NS = 1000;
  localparam int BUS_CLK_LOSS_CYC = BUS_CLK_LOSS_NS / CLK_NS;
  localparam int LOSS_W = 6;
  localparam int BUS_CHANNELS = 256;
  localparam int LOCAL_CHANNELS = 128;
  localparam int CHANNELS = BUS_CHANNELS + LOCAL_CHANNELS;
  localparam int SAMPLE_W = 8;
  localparam int CM_W = 12;
  localparam int CM_HI_W = CM_W - SAMPLE_W;
  localparam int MEM_AW = 9;
  localparam int DMA_CH = 2;
  localparam logic [1:0] REG_ADDR_LO = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_CM_HI = 2'h3;
  localparam int CTRL_ADDR8 = 0;
  localparam int CTRL_SEL_CM = 1;
  localparam int CTRL_DMA_EN = 2;
  localparam int CTRL_ERR = 7;
  localparam logic [7:0] CTRL_WMASK = 8'h07;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  // host waits this long before trusting ready, covering the device synchroniser
  localparam int HOST_SETTLE_CYC = 4;
  localparam int HOST_CNT_W = 3;
  typedef enum logic {TSH_STYLE_STROBE, TSH_STYLE_DS} tsh_style_t;
endpackage

//--- hw/tsh_port_if.sv
// pin-level carrier joining the device end and the host end
`timescale 1ns/10ps
`default_nettype none
interface tsh_port_if;
  logic [7:0] ad_dev_o;
  logic ad_dev_oe;
  logic [7:0] ad_host_o;
  logic ad_host_oe;
  logic [7:0] ad;
  logic [1:0] a;
  logic ale;
  logic cs_n;
  logic rd_ds_n;
  logic wr_rw_n;
  logic rdy_low;
  logic ack_low;
  logic rdy_n;
  logic transfer_ack_n;
  logic err;
  logic [tsh_pkg::DMA_CH-1:0] xfer_request;
  logic [tsh_pkg::DMA_CH-1:0] xfer_grant;
  // pull-ups resolve the released bus and the open-drain lines
  assign ad = ad_dev_oe ? ad_dev_o : (ad_host_oe ? ad_host_o : tsh_pkg::BUS_IDLE);
  assign rdy_n = ~rdy_low;
  assign transfer_ack_n = ~ack_low;
  modport device (input ad, a, ale, cs_n, rd_ds_n, wr_rw_n, xfer_grant,
    output ad_dev_o, ad_dev_oe, rdy_low, ack_low, err, xfer_request);
  modport host (input ad, rdy_n, transfer_ack_n, err, xfer_request,
    output ad_host_o, ad_host_oe, a, ale, cs_n, rd_ds_n, wr_rw_n, xfer_grant);
endinterface
`default_nettype wire

//--- hw/tsh_host.sv
// host end: sequences one bus access per user request and answers DMA requests
`timescale 1ns/10ps
`default_nettype none
module tsh_host (
  input wire logic clk,
  input wire logic rst,
  tsh_port_if.host pins,
  input wire logic style,
  input wire logic mux_mode,
  input wire logic req,
  input wire logic we,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic dma_en,
  input wire logic [7:0] dma_wdata,
  output logic [7:0] rdata,
  output logic done,
  output logic busy
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LATCH, ST_STROBE, ST_WAIT, ST_END}
    tsh_host_state_t;
  tsh_host_state_t state_reg;
  tsh_host_state_t state_next;
  logic [tsh_pkg::HOST_CNT_W-1:0] cnt_reg;
  logic [tsh_pkg::HOST_CNT_W-1:0] cnt_next;
  logic we_reg, we_next;
  logic [1:0] a_reg, a_next;
  logic [7:0] dout_reg, dout_next;
  logic [7:0] rdata_next;
  logic oe_reg, oe_next;
  logic ale_reg, ale_next;
  logic cs_n_reg, cs_n_next;
  logic rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next;
  logic [1:0] gnt_reg, gnt_next;
  logic done_next;
  logic ds_style;
  logic finished;
  assign ds_style = (style == tsh_pkg::TSH_STYLE_DS);
  // ready rises again once the device is done; acknowledge falls
  assign finished = ds_style ? !pins.transfer_ack_n : pins.rdy_n;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    we_next = we_reg;
    a_next = a_reg;
    dout_next = dout_reg;
    rdata_next = rdata;
    oe_next = oe_reg;
    ale_next = 1'b0;
    cs_n_next = cs_n_reg;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    gnt_next = gnt_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        // channel 0 is a DMA read, channel 1 a DMA write of the data port
        if (dma_en && (|pins.xfer_request))
        begin
          gnt_next = pins.xfer_request[0] ? 2'h1 : 2'h2;
          we_next = !pins.xfer_request[0];
          a_next = tsh_pkg::REG_DATA;
          dout_next = dma_wdata;
          state_next = mux_mode ? ST_ADDR : ST_STROBE;
        end
        else if (req)
        begin
          we_next = we;
          a_next = addr;
          dout_next = wdata;
          state_next = mux_mode ? ST_ADDR : ST_STROBE;
        end
      end
      ST_ADDR:
      begin
        ale_next = 1'b1;
        oe_next = 1'b1;
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == tsh_pkg::HOST_CNT_W'(tsh_pkg::HOST_SETTLE_CYC - 1))
        begin
          cnt_next = '0;
          state_next = ST_LATCH;
        end
      end
      ST_LATCH:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == tsh_pkg::HOST_CNT_W'(tsh_pkg::HOST_SETTLE_CYC - 1))
        begin
          cnt_next = '0;
          oe_next = 1'b0;
          state_next = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        cs_n_next = gnt_reg != 2'h0;
        oe_next = we_reg;
        rd_n_next = ds_style ? 1'b0 : we_reg;
        wr_n_next = ds_style ? we_reg == 1'b0 : !we_reg;
        state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cnt_reg != tsh_pkg::HOST_CNT_W'(tsh_pkg::HOST_SETTLE_CYC))
        begin
          cnt_next = cnt_reg + 1'b1;
        end
        else if (finished)
        begin
          rdata_next = pins.ad;
          cnt_next = '0;
          state_next = ST_END;
        end
      end
      default:
      begin
        cs_n_next = 1'b1;
        rd_n_next = 1'b1;
        wr_n_next = !ds_style;
        oe_next = 1'b0;
        if (ds_style ? pins.transfer_ack_n : 1'b1)
        begin
          gnt_next = 2'h0;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      we_reg <= 1'b0;
      a_reg <= 2'h0;
      dout_reg <= 8'h00;
      rdata <= 8'h00;
      oe_reg <= 1'b0;
      ale_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      gnt_reg <= 2'h0;
      done <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      we_reg <= we_next;
      a_reg <= a_next;
      dout_reg <= dout_next;
      rdata <= rdata_next;
      oe_reg <= oe_next;
      ale_reg <= ale_next;
      cs_n_reg <= cs_n_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      gnt_reg <= gnt_next;
      done <= done_next;
      busy <= (state_next != ST_IDLE);
    end
  end

  // multiplexed address phase puts the register index on the bus
  assign pins.ad_host_o = (state_reg == ST_ADDR || state_reg == ST_LATCH) ?
    {6'h00, a_reg} : dout_reg;
  assign pins.ad_host_oe = oe_reg;
  assign pins.a = a_reg;
  assign pins.ale = ale_reg;
  assign pins.cs_n = cs_n_reg;
  assign pins.rd_ds_n = rd_n_reg;
  assign pins.wr_rw_n = wr_n_reg;
  assign pins.xfer_grant = gnt_reg;
endmodule // tsh_host
`default_nettype wire

//--- sim/tsh_props.sv
// concurrent checks on the pins between the device end and the host end
`timescale 1ns/10ps
`default_nettype none
module tsh_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] ad_dev_o,
  input wire logic ad_dev_oe,
  input wire logic ad_host_oe,
  input wire logic cs_n,
  input wire logic rd_ds_n,
  input wire logic wr_rw_n,
  input wire logic rdy_low,
  input wire logic ack_low,
  input wire logic [tsh_pkg::DMA_CH-1:0] xfer_request,
  input wire logic [tsh_pkg::DMA_CH-1:0] xfer_grant
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // an access is live when selected or granted with a strobe low
  wire live = (!cs_n || xfer_grant != 2'h0) && !(rd_ds_n && wr_rw_n);
  // six quiet cycles cover the two-flop synchroniser plus the state and drive flops
  sequence unselected;
    (cs_n && xfer_grant == 2'h0) [*6];
  endsequence
  sequence no_read;
    rd_ds_n [*6];
  endsequence
  bus_release_a: assert property (unselected |-> !ad_dev_oe)
    else $error("bus driven while unselected");
  write_no_drive_a: assert property ((!wr_rw_n) [*6] |-> !ad_dev_oe)
    else $error("bus driven during a write");
  idle_no_drive_a: assert property (no_read |-> !ad_dev_oe)
    else $error("bus driven with no read strobe");
  no_contention_a: assert property (!(ad_dev_oe && ad_host_oe))
    else $error("both ends drive the bus");
  read_stable_a: assert property (ad_dev_oe && $past(ad_dev_oe) |-> $stable(ad_dev_o))
    else $error("read data changed while driven");
  ready_cause_a: assert property ($rose(rdy_low) |-> $past(live, 2))
    else $error("ready pulled low without an access");
  ready_bound_a: assert property (rdy_low |-> ##[1:200] !rdy_low)
    else $error("ready held low too long");
  ready_data_a: assert property ($fell(rdy_low) && !rd_ds_n |-> ad_dev_oe)
    else $error("ready released before read data driven");
  ack_cause_a: assert property ($rose(ack_low) |-> $past(live && !rd_ds_n, 2))
    else $error("acknowledge without a data strobe access");
  ack_hold_a: assert property (ack_low && !rd_ds_n |=> ack_low)
    else $error("acknowledge dropped while strobe held");
  ack_release_a: assert property (no_read |-> !ack_low)
    else $error("acknowledge stuck after strobe release");
  request_hold_a: assert property (($past(xfer_request) & ~xfer_request & ~($past(xfer_grant)
    | $past(xfer_grant, 2) | $past(xfer_grant, 3) | $past(xfer_grant, 4))) == 2'h0)
    else $error("request withdrawn without a grant");
  grant_cause_a: assert property ((xfer_grant & ~$past(xfer_grant)
    & ~$past(xfer_request)) == 2'h0)
    else $error("grant raised without a matching request");
endmodule // tsh_props
`default_nettype wire

//--- sim/tdm_switch_host_port_test.sv
// self-checking bench joining the device end and the host end of the host port
`timescale 1ns/10ps
`default_nettype none
module tdm_switch_host_port_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic style = 1'b0;
  logic mux_mode = 1'b0;
  logic bus_clock_4m = 1'b0;
  logic bc_run = 1'b1;
  logic pll_locked = 1'b1;
  logic [1:0] dma_event = 2'h0;
  logic core_dm_we = 1'b0;
  logic [8:0] core_dm_addr = 9'h000;
  logic [7:0] core_dm_wdata = 8'h00;
  logic [8:0] core_cm_addr = 9'h000;
  logic [11:0] core_cm_q;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic dma_en = 1'b0;
  logic [7:0] dma_wdata = 8'h3C;
  logic [7:0] rdata;
  logic done;
  logic busy;
  logic [11:0] rv;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  int dm_m [0:383];
  int dm_q [$];
  tsh_port_if port_if ();
  tsh_device tsh_device_inst (.clk(clk), .rst(rst), .pins(port_if.device), .style(style),
    .bus_clock_4m(bus_clock_4m), .pll_locked(pll_locked), .dma_event(dma_event),
    .core_dm_we(core_dm_we), .core_dm_addr(core_dm_addr), .core_dm_wdata(core_dm_wdata),
    .core_cm_addr(core_cm_addr), .core_cm_q(core_cm_q));
  tsh_host tsh_host_inst (.clk(clk), .rst(rst), .pins(port_if.host), .style(style),
    .mux_mode(mux_mode), .req(req), .we(we), .addr(addr), .wdata(wdata), .dma_en(dma_en),
    .dma_wdata(dma_wdata), .rdata(rdata), .done(done), .busy(busy));
  tsh_props tsh_props_inst (.clk(clk), .rst(rst), .ad_dev_o(port_if.ad_dev_o),
    .ad_dev_oe(port_if.ad_dev_oe), .ad_host_oe(port_if.ad_host_oe), .cs_n(port_if.cs_n),
    .rd_ds_n(port_if.rd_ds_n), .wr_rw_n(port_if.wr_rw_n), .rdy_low(port_if.rdy_low),
    .ack_low(port_if.ack_low), .xfer_request(port_if.xfer_request),
    .xfer_grant(port_if.xfer_grant));
  always #12.5 clk = ~clk;
  // the bus clock toggles every 125 ns, on a falling edge of clk; stopping it models a lost bus clock
  always #125 if (bc_run) bus_clock_4m = ~bus_clock_4m;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered at a falling edge; leaves two falling edges after done so accesses are spaced
  task automatic acc(input logic w, input logic [1:0] ra, input logic [7:0] d);
    int n;
    req = 1'b1;
    we = w;
    addr = ra;
    wdata = d;
    @(negedge clk);
    req = 1'b0;
    chk(12'(busy), 12'h001);
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(12'(n < 400), 12'h001);
    chk(12'(busy), 12'h000);
    rv = 12'(rdata);
    repeat (2) @(negedge clk);
  endtask
  task automatic point(input int a, input logic [1:0] ctl);
    acc(1'b1, tsh_pkg::REG_ADDR_LO, a[7:0]);
    acc(1'b1, tsh_pkg::REG_CTRL, {5'h00, ctl, a[8]});
  endtask
  task automatic do_reset(input logic s, input logic m);
    rst = 1'b1;
    style = s;
    mux_mode = m;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int a;
    int b;
    int v;
    int lo;
    int hi;
    void'($urandom(144));
    for (int cfg = 0; cfg < 3; cfg++)
    begin
      do_reset(cfg == 2, cfg == 1);
      acc(1'b0, tsh_pkg::REG_CTRL, 8'h00);
      chk(rv, 12'h000);
      foreach (dm_q[i])
      begin
        point(dm_q[i], 2'h0);
        acc(1'b0, tsh_pkg::REG_DATA, 8'h00);
        chk(rv, 12'(dm_m[dm_q[i]]));
      end
      repeat (3)
      begin
        a = $urandom_range(383);
        b = (a + 1 + $urandom_range(100)) % 384;
        v = $urandom_range(255);
        dm_m[b] = $urandom_range(255);
        point(a, 2'h0);
        fork
          acc(1'b1, tsh_pkg::REG_DATA, 8'(v));
          begin
            // lands the core write in the cycle the device would commit the host write
            repeat (mux_mode ? 13 : 5) @(negedge clk);
            core_dm_we = 1'b1;
            core_dm_addr = 9'(b);
            core_dm_wdata = 8'(dm_m[b]);
            @(negedge clk);
            core_dm_we = 1'b0;
          end
        join
        dm_m[a] = v;
        dm_q.push_back(a);
        dm_q.push_back(b);
        acc(1'b0, tsh_pkg::REG_DATA, 8'h00);
        chk(rv, 12'(v));
        point(b, 2'h0);
        acc(1'b0, tsh_pkg::REG_DATA, 8'h00);
        chk(rv, 12'(dm_m[b]));
      end
      a = $urandom_range(383);
      lo = $urandom_range(255);
      hi = $urandom_range(15);
      v = lo ^ 8'hA5;
      core_cm_addr = 9'(a);
      point(a, 2'h1);
      acc(1'b1, tsh_pkg::REG_DATA, 8'(lo));
      acc(1'b1, tsh_pkg::REG_CM_HI, 8'(hi));
      chk(core_cm_q, 12'(hi * 256 + lo));
      acc(1'b1, tsh_pkg::REG_DATA, 8'(v));
      chk(core_cm_q, 12'(hi * 256 + lo));
      acc(1'b1, tsh_pkg::REG_CM_HI, 8'(15 - hi));
      chk(core_cm_q, 12'((15 - hi) * 256 + v));
      acc(1'b0, tsh_pkg::REG_CM_HI, 8'h00);
      chk(rv, 12'(15 - hi));
      acc(1'b0, tsh_pkg::REG_DATA, 8'h00);
      chk(rv, 12'(v));
      $display("test config %0d done", cfg);
    end
    point(0, 2'h2);
    dma_en = 1'b1;
    for (int ch = 0; ch < 2; ch++)
    begin
      dma_event = 2'(1 << ch);
      @(negedge clk);
      dma_event = 2'h0;
      chk(12'(port_if.xfer_request[ch]), 12'h001);
      repeat (100) @(negedge clk);
      chk(12'(port_if.xfer_request), 12'h000);
    end
    // the channel 1 transfer wrote the data port at the pointed address
    acc(1'b0, tsh_pkg::REG_DATA, 8'h00);
    chk(rv, 12'(dma_wdata));
    // with the controller silent a second event overruns the pending request
    dma_en = 1'b0;
    repeat (2)
    begin
      dma_event = 2'h1;
      @(negedge clk);
      dma_event = 2'h0;
      @(negedge clk);
    end
    // overrun flag and error flop each add one cycle
    @(negedge clk);
    chk(12'(port_if.err), 12'h001);
    acc(1'b0, tsh_pkg::REG_CTRL, 8'h00);
    chk(rv, 12'h084);
    $display("test dma done");
    do_reset(1'b1, 1'b0);
    chk(12'(port_if.err), 12'h000);
    pll_locked = 1'b0;
    repeat (4) @(negedge clk);
    chk(12'(port_if.err), 12'h001);
    pll_locked = 1'b1;
    do_reset(1'b0, 1'b0);
    bc_run = 1'b0;
    repeat (60) @(negedge clk);
    chk(12'(port_if.err), 12'h001);
    acc(1'b0, tsh_pkg::REG_CTRL, 8'h00);
    chk(rv, 12'h080);
    bc_run = 1'b1;
    do_reset(1'b0, 1'b0);
    acc(1'b0, tsh_pkg::REG_CTRL, 8'h00);
    chk(rv, 12'h000);
    $display("test error sources done");
    tally_and_finish();
  end
endmodule // tdm_switch_host_port_test
`default_nettype wire
